// ### src/pdor_pkg.sv
// Shared constants, types and helpers for the port direction/output register block
`default_nettype none

package pdor_pkg;

  localparam int PDOR_PINS = 32;
  localparam int PDOR_AW = 8;

  // Byte offsets of the register words
  localparam logic [7:0] PDOR_OFS_DIR = 8'h00;
  localparam logic [7:0] PDOR_OFS_DIR_CLR = 8'h04;
  localparam logic [7:0] PDOR_OFS_DIR_SET = 8'h08;
  localparam logic [7:0] PDOR_OFS_DIR_TGL = 8'h0C;
  localparam logic [7:0] PDOR_OFS_OUT = 8'h10;
  localparam logic [7:0] PDOR_OFS_OUT_CLR = 8'h14;
  localparam logic [7:0] PDOR_OFS_OUT_SET = 8'h18;
  localparam logic [7:0] PDOR_OFS_OUT_TGL = 8'h1C;
  localparam logic [7:0] PDOR_OFS_PULL = 8'h40;

  // Field positions inside a byte address
  localparam int PDOR_GRP_LSB = 4;
  localparam int PDOR_OP_LSB = 2;

  localparam logic [31:0] PDOR_RST_WORD = 32'h00000000;

  localparam logic [1:0] PDOR_RESP_OKAY = 2'h0;
  localparam logic [1:0] PDOR_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PDOR_OP_WRITE,
    PDOR_OP_CLEAR,
    PDOR_OP_SET,
    PDOR_OP_TOGGLE
  } pdor_op_t;

  // Pad-facing controls, one bit per pin of the group
  typedef struct packed {
    logic [PDOR_PINS-1:0] drive_en;
    logic [PDOR_PINS-1:0] drive_level;
    logic [PDOR_PINS-1:0] pull_up;
    logic [PDOR_PINS-1:0] pull_down;
  } pdor_pins_t;

  // Applies one write to a register word; only strobed one bits act on the aliases
  function automatic logic [31:0] pdor_apply(
    input pdor_op_t op,
    input logic [31:0] cur,
    input logic [31:0] data,
    input logic [31:0] mask
  );
    logic [31:0] hit;
    hit = data & mask;
    case (op)
      PDOR_OP_WRITE: pdor_apply = (cur & ~mask) | hit;
      PDOR_OP_CLEAR: pdor_apply = cur & ~hit;
      PDOR_OP_SET: pdor_apply = cur | hit;
      PDOR_OP_TOGGLE: pdor_apply = cur ^ hit;
      default: pdor_apply = cur;
    endcase
  endfunction : pdor_apply

endpackage : pdor_pkg

`default_nettype wire

// ### src/pdor_pin_drive.sv
// Registered pad driver and pull selection for one pin group
`timescale 1ns/1ns
`default_nettype none

module pdor_pin_drive #(
  parameter int PINS = pdor_pkg::PDOR_PINS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [PINS-1:0] dir,
  input wire logic [PINS-1:0] level,
  input wire logic [PINS-1:0] pull_en,
  output pdor_pkg::pdor_pins_t pins
);

  pdor_pkg::pdor_pins_t pins_reg;
  pdor_pkg::pdor_pins_t pins_next;

  always_comb begin
    pins_next.drive_en = dir;
    pins_next.drive_level = level & dir;
    // Driver on means pull off, so the two never fight
    pins_next.pull_up = ~dir & pull_en & level;
    pins_next.pull_down = ~dir & pull_en & ~level;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_reg <= '0;
    end else begin
      pins_reg <= pins_next;
    end
  end

  assign pins = pins_reg;

endmodule : pdor_pin_drive

`default_nettype wire

// ### src/pdor_port_regs.sv
// AXI4-Lite register file for pin direction and output level of one port group
//
// Contract
// - Direction bit zero makes its pin an input.
// - Direction bit one makes its pin an output with driver enabled.
// - Ones written to direction-clear alias clear matching direction bits.
// - Ones written to direction-set alias set matching direction bits.
// - Ones written to direction-toggle alias invert matching direction bits.
// - Zero bits written to any alias leave the register unchanged.
// - Direction word and all its aliases read the same current value.
// - An output pin drives low for level bit 0, high for 1.
// - Input with pull enabled: level 0 pulls down, level 1 pulls up.
// - An output-clear alias lets software drive pins low without read-modify-write.
// - Output-level word and all its aliases read the same current value.
// - Direction and level words hold one bit per pin, bits 31 to 0.
// - Ones written to output-clear alias clear matching level bits.
// - Ones written to output-set alias set matching level bits.
// - Ones written to output-toggle alias invert matching level bits.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module pdor_port_regs #(
  parameter int PINS = pdor_pkg::PDOR_PINS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output pdor_pkg::pdor_pins_t pins
);

  logic [PINS-1:0] dir_reg, dir_next;
  logic [PINS-1:0] out_reg, out_next;
  logic [PINS-1:0] pull_reg, pull_next;

  logic aw_full_reg, aw_full_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic w_full_reg, w_full_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;

  logic aw_fire, w_fire, ar_fire, wr_go;
  logic [31:0] wmask;
  pdor_pkg::pdor_op_t wr_op;
  logic [31:0] wr_dir_word, wr_out_word, wr_pull_word;

  assign aw_fire = s_axi_awvalid && awready_reg;
  assign w_fire = s_axi_wvalid && wready_reg;
  assign ar_fire = s_axi_arvalid && arready_reg;
  // Only one response may be outstanding, so a held pair waits for bready
  assign wr_go = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  assign wr_op = pdor_pkg::pdor_op_t'(awaddr_reg[pdor_pkg::PDOR_OP_LSB +: 2]);
  assign wr_dir_word = pdor_pkg::pdor_apply(wr_op, 32'(dir_reg), wdata_reg, wmask);
  assign wr_out_word = pdor_pkg::pdor_apply(wr_op, 32'(out_reg), wdata_reg, wmask);
  assign wr_pull_word = pdor_pkg::pdor_apply(pdor_pkg::PDOR_OP_WRITE, 32'(pull_reg), wdata_reg,
    wmask);

  // Write path: address and data are held independently, then applied together
  always_comb begin
    aw_full_next = aw_full_reg;
    awaddr_next = awaddr_reg;
    w_full_next = w_full_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    dir_next = dir_reg;
    out_next = out_reg;
    pull_next = pull_reg;
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (aw_fire) begin
      aw_full_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (w_fire) begin
      w_full_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (wr_go) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = pdor_pkg::PDOR_RESP_OKAY;
      if (awaddr_reg[7:pdor_pkg::PDOR_GRP_LSB] == pdor_pkg::PDOR_OFS_DIR[7:pdor_pkg::PDOR_GRP_LSB])
      begin
        dir_next = wr_dir_word[PINS-1:0];
      end else if (awaddr_reg[7:pdor_pkg::PDOR_GRP_LSB] ==
                   pdor_pkg::PDOR_OFS_OUT[7:pdor_pkg::PDOR_GRP_LSB]) begin
        out_next = wr_out_word[PINS-1:0];
      end else if (awaddr_reg[7:2] == pdor_pkg::PDOR_OFS_PULL[7:2]) begin
        pull_next = wr_pull_word[PINS-1:0];
      end else begin
        bresp_next = pdor_pkg::PDOR_RESP_SLVERR;
      end
    end
    awready_next = !aw_full_next;
    wready_next = !w_full_next;
  end

  // Read path: one read at a time, data captured at the address handshake
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (ar_fire) begin
      rvalid_next = 1'b1;
      rresp_next = pdor_pkg::PDOR_RESP_OKAY;
      case (s_axi_araddr[7:2])
        pdor_pkg::PDOR_OFS_DIR[7:2],
        pdor_pkg::PDOR_OFS_DIR_CLR[7:2],
        pdor_pkg::PDOR_OFS_DIR_SET[7:2],
        pdor_pkg::PDOR_OFS_DIR_TGL[7:2]: begin
          rdata_next = 32'(dir_reg);
        end
        pdor_pkg::PDOR_OFS_OUT[7:2],
        pdor_pkg::PDOR_OFS_OUT_CLR[7:2],
        pdor_pkg::PDOR_OFS_OUT_SET[7:2],
        pdor_pkg::PDOR_OFS_OUT_TGL[7:2]: begin
          rdata_next = 32'(out_reg);
        end
        pdor_pkg::PDOR_OFS_PULL[7:2]: begin
          rdata_next = 32'(pull_reg);
        end
        default: begin
          rdata_next = pdor_pkg::PDOR_RST_WORD;
          rresp_next = pdor_pkg::PDOR_RESP_SLVERR;
        end
      endcase
    end
    arready_next = !rvalid_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_reg <= PINS'(pdor_pkg::PDOR_RST_WORD);
      out_reg <= PINS'(pdor_pkg::PDOR_RST_WORD);
      pull_reg <= PINS'(pdor_pkg::PDOR_RST_WORD);
      aw_full_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      w_full_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= 2'h0;
    end else begin
      dir_reg <= dir_next;
      out_reg <= out_next;
      pull_reg <= pull_next;
      aw_full_reg <= aw_full_next;
      awaddr_reg <= awaddr_next;
      w_full_reg <= w_full_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  pdor_pin_drive #(
    .PINS(PINS)
  ) u_pin_drive (
    .aclk(aclk),
    .aresetn(aresetn),
    .dir(dir_reg),
    .level(out_reg),
    .pull_en(pull_reg),
    .pins(pins)
  );

  // Helpers that only the checks read
  logic wr_dir_hit, wr_out_hit;
  assign wr_dir_hit = wr_go && awaddr_reg[7:4] == pdor_pkg::PDOR_OFS_DIR[7:4];
  assign wr_out_hit = wr_go && awaddr_reg[7:4] == pdor_pkg::PDOR_OFS_OUT[7:4];

  chk_dir_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> pins.drive_en == $past(dir_reg))
    else $error("driver enable does not follow direction");

  chk_drive_level: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> (pins.drive_level & pins.drive_en) == ($past(out_reg) & pins.drive_en))
    else $error("output pin level does not follow level bit");

  chk_pull_select: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> pins.pull_up == ($past(pull_reg) & ~pins.drive_en & $past(out_reg))
      && pins.pull_down == ($past(pull_reg) & ~pins.drive_en & ~$past(out_reg)))
    else $error("pull selection wrong for input pin");

  chk_dir_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_dir_hit && wr_op == pdor_pkg::PDOR_OP_CLEAR |=>
      dir_reg == ($past(dir_reg) & ~$past(wdata_reg[PINS-1:0] & wmask[PINS-1:0])))
    else $error("direction clear alias misbehaves");

  chk_dir_set: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_dir_hit && wr_op == pdor_pkg::PDOR_OP_SET |=>
      dir_reg == ($past(dir_reg) | $past(wdata_reg[PINS-1:0] & wmask[PINS-1:0])))
    else $error("direction set alias misbehaves");

  chk_dir_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_dir_hit && wr_op == pdor_pkg::PDOR_OP_TOGGLE |=>
      dir_reg == ($past(dir_reg) ^ $past(wdata_reg[PINS-1:0] & wmask[PINS-1:0])))
    else $error("direction toggle alias misbehaves");

  chk_out_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_out_hit && wr_op == pdor_pkg::PDOR_OP_CLEAR |=>
      out_reg == ($past(out_reg) & ~$past(wdata_reg[PINS-1:0] & wmask[PINS-1:0])))
    else $error("output clear alias misbehaves");

  chk_out_set: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_out_hit && wr_op == pdor_pkg::PDOR_OP_SET |=>
      out_reg == ($past(out_reg) | $past(wdata_reg[PINS-1:0] & wmask[PINS-1:0])))
    else $error("output set alias misbehaves");

  chk_out_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_out_hit && wr_op == pdor_pkg::PDOR_OP_TOGGLE |=>
      out_reg == ($past(out_reg) ^ $past(wdata_reg[PINS-1:0] & wmask[PINS-1:0])))
    else $error("output toggle alias misbehaves");

  chk_dir_readback: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_fire && s_axi_araddr[7:4] == pdor_pkg::PDOR_OFS_DIR[7:4] |=>
      s_axi_rvalid && s_axi_rdata == 32'($past(dir_reg)))
    else $error("direction alias read differs");

  chk_out_readback: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_fire && s_axi_araddr[7:4] == pdor_pkg::PDOR_OFS_OUT[7:4] |=>
      s_axi_rvalid && s_axi_rdata == 32'($past(out_reg)))
    else $error("output alias read differs");

  chk_reset_zero: assert property (@(posedge aclk)
    !aresetn |=> dir_reg == '0 && out_reg == '0)
    else $error("registers not zero after reset");

  chk_resp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");

  cov_dir_toggle: cover property (@(posedge aclk) disable iff (!aresetn)
    wr_dir_hit && wr_op == pdor_pkg::PDOR_OP_TOGGLE);
  cov_out_clear: cover property (@(posedge aclk) disable iff (!aresetn)
    wr_out_hit && wr_op == pdor_pkg::PDOR_OP_CLEAR);
  cov_pull_up: cover property (@(posedge aclk) disable iff (!aresetn) pins.pull_up != '0);
  cov_bad_addr: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rresp == pdor_pkg::PDOR_RESP_SLVERR);

endmodule : pdor_port_regs

`default_nettype wire

// ### tb/pdor_port_regs_tb_top.sv
// Self-checking bench for the port direction and output-level register block
`timescale 1ns/1ns
`default_nettype none

module pdor_port_regs_tb_top;
  logic aclk;
  logic aresetn;
  logic [7:0] awaddr;
  logic awvalid;
  logic awready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [7:0] araddr;
  logic arvalid;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  pdor_pkg::pdor_pins_t pins;
  int errors;
  int checks;
  int cycles;
  logic [7:0] ofs_tab [9];

  pdor_port_regs u_pdor_port_regs (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pins(pins)
  );

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic wrap_up();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // Every scenario together needs well under a thousand cycles
  always @(posedge aclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      $display("wrong value watchdog expected done seen hang");
      wrap_up();
    end
  end

  task automatic cmp_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp_word

  task automatic cmp_resp(input string nm, input logic [1:0] exp, input logic [1:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp_resp

  // Leading edge keeps two transfers from driving the same signal in one step
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    logic got_b;
    got_b = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got_b) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        got_b = 1'b1;
        bready <= 1'b0;
      end
    end
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic got_r;
    got_r = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got_r) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        got_r = 1'b1;
        rready <= 1'b0;
      end
    end
  endtask : axi_read

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] v;
    logic [1:0] r;
    axi_read(a, v, r);
    cmp_resp("rresp", er, r);
    cmp_word("rdata", exp, v);
  endtask : rd_chk

  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [7:0] ra, input logic [31:0] exp);
    logic [1:0] r;
    axi_write(a, d, s, r);
    cmp_resp("bresp", pdor_pkg::PDOR_RESP_OKAY, r);
    rd_chk(ra, exp, pdor_pkg::PDOR_RESP_OKAY);
  endtask : wr_chk

  // Pads lag the registers by one clock; a read in between covers that
  task automatic pin_chk(input logic [31:0] d, input logic [31:0] l, input logic [31:0] p);
    cmp_word("drive_en", d, pins.drive_en);
    cmp_word("drive_level", l & d, pins.drive_level);
    cmp_word("pull_up", ~d & p & l, pins.pull_up);
    cmp_word("pull_down", ~d & p & ~l, pins.pull_down);
  endtask : pin_chk

  task automatic t_reset();
    for (int i = 0; i < 9; i++) rd_chk(ofs_tab[i], 32'h0, pdor_pkg::PDOR_RESP_OKAY);
    pin_chk(32'h0, 32'h0, 32'h0);
  endtask : t_reset

  task automatic t_dir();
    wr_chk(8'h00, 32'hF0F0F0F0, 4'hF, 8'h00, 32'hF0F0F0F0);
    wr_chk(8'h08, 32'h0000000F, 4'hF, 8'h00, 32'hF0F0F0FF);
    wr_chk(8'h04, 32'hF0000001, 4'hF, 8'h00, 32'h00F0F0FE);
    wr_chk(8'h0C, 32'h800000FF, 4'hF, 8'h00, 32'h80F0F001);
    for (int i = 0; i < 4; i++) rd_chk(ofs_tab[i], 32'h80F0F001, 2'h0);
  endtask : t_dir

  task automatic t_out();
    wr_chk(8'h40, 32'h0000FFFF, 4'hF, 8'h40, 32'h0000FFFF);
    wr_chk(8'h10, 32'h12345678, 4'hF, 8'h10, 32'h12345678);
    wr_chk(8'h18, 32'h00000081, 4'hF, 8'h10, 32'h123456F9);
    wr_chk(8'h14, 32'h12000070, 4'hF, 8'h10, 32'h00345689);
    wr_chk(8'h1C, 32'hFF00000F, 4'hF, 8'h10, 32'hFF345686);
    for (int i = 4; i < 8; i++) rd_chk(ofs_tab[i], 32'hFF345686, 2'h0);
    pin_chk(32'h80F0F001, 32'hFF345686, 32'h0000FFFF);
  endtask : t_out

  // Unstrobed lanes act as zero bits on aliases and stay put on plain words
  task automatic t_strb_err();
    logic [1:0] r;
    wr_chk(8'h08, 32'hFFFFFFFF, 4'h1, 8'h00, 32'h80F0F0FF);
    wr_chk(8'h0C, 32'h00000000, 4'hF, 8'h0C, 32'h80F0F0FF);
    wr_chk(8'h10, 32'hAAAAAAAA, 4'h2, 8'h14, 32'hFF34AA86);
    axi_write(8'h20, 32'hFFFFFFFF, 4'hF, r);
    cmp_resp("bresp", pdor_pkg::PDOR_RESP_SLVERR, r);
    rd_chk(8'h20, 32'h0, pdor_pkg::PDOR_RESP_SLVERR);
    rd_chk(8'h00, 32'h80F0F0FF, pdor_pkg::PDOR_RESP_OKAY);
    pin_chk(32'h80F0F0FF, 32'hFF34AA86, 32'h0000FFFF);
  endtask : t_strb_err

  // Late bready: the response has to wait, unchanged, for the master
  task automatic t_late_b();
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= 8'h1C;
    wdata <= 32'h000000F0;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (awvalid || wvalid || !bvalid) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    repeat (2) @(posedge aclk);
    cmp_word("bvalid", 32'h00000001, {31'h0, bvalid});
    cmp_resp("bresp", pdor_pkg::PDOR_RESP_OKAY, bresp);
    bready <= 1'b1;
    @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
    cmp_resp("bresp", pdor_pkg::PDOR_RESP_OKAY, r);
    rd_chk(8'h10, 32'hFF34AA76, pdor_pkg::PDOR_RESP_OKAY);
  endtask : t_late_b

  task automatic t_mid_reset();
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
  endtask : t_mid_reset

  initial begin
    ofs_tab = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h40};
    errors = 0;
    checks = 0;
    cycles = 0;
    aresetn = 1'b0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_dir();
    t_out();
    t_strb_err();
    t_late_b();
    t_mid_reset();
    wrap_up();
  end
endmodule : pdor_port_regs_tb_top

`default_nettype wire
